// [tlvic_ctrl.sv]
// two-level vectored interrupt controller with an AXI4-Lite register port
//
// Function
// - Twelve sources each own a fixed vector and a fixed arbitration position.
// - Software writing a one to a pending flag raises a request just like a hardware event.
// - Each source has one priority bit, held in two priority select registers.
// - High level preempts a low routine; nothing preempts a high routine.
// - All priority bits reset to low.
// - High level wins first, then the lowest order number among equals.
// - Pending requests are sampled and decoded on every clock.
// - Response is one detect cycle plus four for the long call, five at least.
// - A request pending at return waits for exactly one more instruction.
// - Worst response without nesting is eighteen cycles: detect, return, divide, call.
// - Equal or lower level requests wait until the running routine's return and next instruction.
// - Reset vectors to 0x0000; sources vector from 0x0003 in steps of eight up to 0x005B.
// - Only both pin flags and timers 0 and 1 overflow flags are cleared by hardware on vectoring.
// - The global enable masks all sources; when set each source follows its own enable.
// - Pending flags set on events whatever the enables; disabled ones are ignored.
// - A flag still set after return raises a new request taken after the next instruction.
`timescale 1ns/1ps
`default_nettype none
module tlvic_ctrl
	import tlvic_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk_in,
	input  wire logic              reset_n_in,
	// peripheral flag sources, one-cycle pulses
	input  wire logic [NUM_SRC-1:0] src_event_in,
	// core sequencer
	input  wire logic              irq_ack_in,
	input  wire logic              return_from_irq_instr_done_in,
	input  wire logic              instr_done_in,
	output tlvic_req_t             irq_req_out,
	// pending flags for peripheral read-back
	output logic [NUM_SRC-1:0]     pending_out,
	// AXI4-Lite write channels
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	output logic [1:0]             s_axi_bresp_out,
	// AXI4-Lite read channels
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	output logic [31:0]            s_axi_rdata_out,
	output logic [1:0]             s_axi_rresp_out
);

	// register state
	logic [NUM_SRC-1:0]    en_reg;
	logic                  global_irq_enable;
	logic [PRIO_SPLIT-1:0] priority_select_reg;
	logic [PRIO_SPLIT-1:0] extended_priority_select_reg;
	logic [NUM_SRC-1:0]    pend_reg;
	logic [NUM_SRC-1:0]    pend_next;
	logic                  isr_low_reg;
	logic                  isr_high_reg;
	tlvic_fsm_t            fsm_reg;
	tlvic_fsm_t            fsm_next;
	logic [2:0]            call_cnt_reg;
	tlvic_req_t            req_reg;
	tlvic_req_t            req_next;

	// bus state
	logic                  awready_reg;
	logic                  wready_reg;
	logic                  bvalid_reg;
	logic [1:0]            bresp_reg;
	logic [ADDR_W-1:0]     waddr_reg;
	logic [31:0]           wdata_reg;
	logic [3:0]            wstrb_reg;
	logic                  arready_reg;
	logic                  rvalid_reg;
	logic [31:0]           rdata_reg;
	logic [1:0]            rresp_reg;

	// write decode: both halves held and no answer outstanding
	wire                   aw_fire  = s_axi_awvalid_in & awready_reg;
	wire                   w_fire   = s_axi_wvalid_in & wready_reg;
	wire                   wr_do    = ~awready_reg & ~wready_reg & ~bvalid_reg;
	wire [31:0]            wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	wire                   sel_en   = wr_do & (waddr_reg == ADDR_ENABLE);
	wire                   sel_pr   = wr_do & (waddr_reg == ADDR_PRIO);
	wire                   sel_epr  = wr_do & (waddr_reg == ADDR_EXT_PRIO);
	wire                   sel_pend = wr_do & (waddr_reg == ADDR_PENDING);
	wire                   wr_known = (waddr_reg == ADDR_ENABLE) | (waddr_reg == ADDR_PRIO)
		| (waddr_reg == ADDR_EXT_PRIO) | (waddr_reg == ADDR_PENDING)
		| (waddr_reg == ADDR_STATUS);
	wire [31:0]            wr_merge_en = (wdata_reg & wmask)
		| ({global_irq_enable, 19'h00000, en_reg} & ~wmask);
	wire [NUM_SRC-1:0]     sw_mask  = sel_pend ? wmask[NUM_SRC-1:0] : '0;
	wire [NUM_SRC-1:0]     sw_set   = sw_mask & wdata_reg[NUM_SRC-1:0];
	wire [NUM_SRC-1:0]     sw_clr   = sw_mask & ~wdata_reg[NUM_SRC-1:0];

	// request candidates
	wire [NUM_SRC-1:0]     prio_all = {extended_priority_select_reg, priority_select_reg};
	wire [NUM_SRC-1:0]     cand     = pend_reg & en_reg & {NUM_SRC{global_irq_enable}};
	wire [NUM_SRC-1:0]     cand_hi  = cand & prio_all;
	wire [NUM_SRC-1:0]     cand_lo  = cand & ~prio_all;
	wire                   hi_ok    = (|cand_hi) & ~isr_high_reg;
	wire                   lo_ok    = (|cand_lo) & ~isr_high_reg & ~isr_low_reg;
	wire [NUM_SRC-1:0]     pick_set = hi_ok ? cand_hi : cand_lo;
	wire                   grant_ok = (fsm_reg == ST_RUN) & (hi_ok | lo_ok);
	logic [SRC_W-1:0]      win_src;
	wire [15:0]            win_vec  = 16'(VEC_BASE + VEC_STEP * {12'h000, win_src});
	wire [NUM_SRC-1:0]     ack_clr  = (irq_ack_in && req_reg.valid)
		? (HW_CLR_MASK & NUM_SRC'(1 << req_reg.src)) : '0;

	// lowest order number wins among the chosen level
	always_comb
	begin
		win_src = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (pick_set[i])
			begin
				win_src = SRC_W'(i);
			end
		end
	end

	// hardware set wins over any clear in the same cycle
	assign pend_next = (pend_reg & ~ack_clr & ~sw_clr) | src_event_in | sw_set;

	// request sequencing toward the core
	always_comb
	begin
		fsm_next = fsm_reg;
		unique case (fsm_reg)
			ST_RUN:
			begin
				if (irq_ack_in && req_reg.valid)
				begin
					fsm_next = ST_CALL;
				end
				else if (return_from_irq_instr_done_in)
				begin
					fsm_next = ST_HOLD;
				end
			end
			ST_CALL:
			begin
				if (call_cnt_reg == LONG_CALL_INSTR_LAST)
				begin
					fsm_next = ST_RUN;
				end
			end
			ST_HOLD:
			begin
				if (instr_done_in)
				begin
					fsm_next = ST_RUN;
				end
			end
			default:
			begin
				fsm_next = ST_RUN;
			end
		endcase
	end

	always_comb
	begin
		req_next        = req_reg;
		req_next.valid  = grant_ok & ~irq_ack_in & ~return_from_irq_instr_done_in;
		if (grant_ok)
		begin
			req_next.level  = hi_ok;
			req_next.src    = win_src;
			req_next.vector = win_vec;
		end
	end

	// interrupt state
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			pend_reg     <= '0;
			isr_low_reg  <= 1'b0;
			isr_high_reg <= 1'b0;
			fsm_reg      <= ST_RUN;
			call_cnt_reg <= '0;
			req_reg      <= '{valid: 1'b0, level: 1'b0, src: '0, vector: RESET_VECTOR};
		end
		else
		begin
			pend_reg     <= pend_next;
			fsm_reg      <= fsm_next;
			call_cnt_reg <= (fsm_reg == ST_CALL) ? call_cnt_reg + 3'h1 : 3'h0;
			req_reg      <= req_next;
			if (irq_ack_in && req_reg.valid && req_reg.level)
			begin
				isr_high_reg <= 1'b1;
			end
			else if (irq_ack_in && req_reg.valid)
			begin
				isr_low_reg <= 1'b1;
			end
			else if (return_from_irq_instr_done_in && isr_high_reg)
			begin
				isr_high_reg <= 1'b0;
			end
			else if (return_from_irq_instr_done_in)
			begin
				isr_low_reg <= 1'b0;
			end
		end
	end

	// software registers
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			en_reg                       <= EN_RESET;
			global_irq_enable            <= 1'b0;
			priority_select_reg          <= PRIO_RESET;
			extended_priority_select_reg <= PRIO_RESET;
		end
		else
		begin
			if (sel_en)
			begin
				en_reg            <= wr_merge_en[NUM_SRC-1:0];
				global_irq_enable <= wr_merge_en[GLOBAL_EN_BIT];
			end
			if (sel_pr && wstrb_reg[0])
			begin
				priority_select_reg <= wdata_reg[PRIO_SPLIT-1:0];
			end
			if (sel_epr && wstrb_reg[0])
			begin
				extended_priority_select_reg <= wdata_reg[PRIO_SPLIT-1:0];
			end
		end
	end

	// read mux
	wire [31:0]            status_word = {req_reg.vector, 6'h00, fsm_reg,
		req_reg.src, req_reg.level, req_reg.valid, isr_high_reg, isr_low_reg};
	logic [31:0]           rd_word;
	logic                  rd_known;
	always_comb
	begin
		rd_known = 1'b1;
		unique case (s_axi_araddr_in)
			ADDR_ENABLE:   rd_word = {global_irq_enable, 19'h00000, en_reg};
			ADDR_PRIO:     rd_word = {26'h0000000, priority_select_reg};
			ADDR_EXT_PRIO: rd_word = {26'h0000000, extended_priority_select_reg};
			ADDR_PENDING:  rd_word = {20'h00000, pend_reg};
			ADDR_STATUS:   rd_word = status_word;
			default:
			begin
				rd_word  = 32'h00000000;
				rd_known = 1'b0;
			end
		endcase
	end

	// AXI4-Lite slave: address and data taken in either order, answer one cycle after both
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			waddr_reg   <= '0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= RESP_OKAY;
		end
		else
		begin
			if (aw_fire)
			begin
				awready_reg <= 1'b0;
				waddr_reg   <= s_axi_awaddr_in;
			end
			if (w_fire)
			begin
				wready_reg <= 1'b0;
				wdata_reg  <= s_axi_wdata_in;
				wstrb_reg  <= s_axi_wstrb_in;
			end
			if (wr_do)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_reg && s_axi_bready_in)
			begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
			if (s_axi_arvalid_in && arready_reg)
			begin
				arready_reg <= 1'b0;
				rvalid_reg  <= 1'b1;
				rdata_reg   <= rd_word;
				rresp_reg   <= rd_known ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rvalid_reg && s_axi_rready_in)
			begin
				rvalid_reg  <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	assign irq_req_out       = req_reg;
	assign pending_out       = pend_reg;
	assign s_axi_awready_out = awready_reg;
	assign s_axi_wready_out  = wready_reg;
	assign s_axi_bvalid_out  = bvalid_reg;
	assign s_axi_bresp_out   = bresp_reg;
	assign s_axi_arready_out = arready_reg;
	assign s_axi_rvalid_out  = rvalid_reg;
	assign s_axi_rdata_out   = rdata_reg;
	assign s_axi_rresp_out   = rresp_reg;

	// checks
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	AST_HW_CLEAR: assert property ((irq_ack_in && req_reg.valid
		&& HW_CLR_MASK[req_reg.src] && !src_event_in[req_reg.src] && !sel_pend)
		|=> !pend_reg[$past(req_reg.src)])
		else $error("hardware-cleared flag survived vectoring");
	AST_HIGH_NO_PREEMPT: assert property (isr_high_reg |-> !req_reg.valid)
		else $error("request raised during a high-level routine");
	AST_LOW_PREEMPT: assert property ((isr_low_reg && grant_ok && hi_ok
		&& !irq_ack_in && !return_from_irq_instr_done_in) |=> (req_reg.valid && req_reg.level))
		else $error("high request did not preempt a low routine");
	AST_DETECT_ONE: assert property ((grant_ok && !irq_ack_in && !return_from_irq_instr_done_in)
		|=> req_reg.valid)
		else $error("request not raised one cycle after detection");
	AST_LONG_CALL_INSTR_GAP: assert property ((irq_ack_in && req_reg.valid) |=> !req_reg.valid [*4])
		else $error("request raised during the long call");
	AST_AFTER_RETURN_FROM_IRQ_INSTR: assert property ((fsm_reg == ST_RUN && return_from_irq_instr_done_in && !irq_ack_in)
		|=> (fsm_reg == ST_HOLD && !req_reg.valid) ##1 !req_reg.valid)
		else $error("request raised before the instruction after return");
	AST_PRIO_STABLE: assert property (!(sel_pr || sel_epr) |=> $stable(prio_all))
		else $error("priority bits changed without a write");
	AST_GLOBAL_MASK: assert property (!global_irq_enable |=> !req_reg.valid)
		else $error("request raised while globally disabled");
	AST_VECTOR: assert property (req_reg.valid
		|-> (req_reg.vector[2:0] == VEC_BASE[2:0] && req_reg.vector <= VEC_LAST
		&& req_reg.vector == 16'(VEC_BASE + VEC_STEP * {12'h000, req_reg.src})))
		else $error("vector does not match its source");
	AST_FLAG_SET: assert property (1'b1 |=> ((pend_reg & $past(src_event_in))
		== $past(src_event_in)))
		else $error("pending flag lost an event");
	AST_RETURN_FROM_IRQ_INSTR_HIGH: assert property ((return_from_irq_instr_done_in && isr_high_reg && !irq_ack_in)
		|=> (!isr_high_reg && $stable(isr_low_reg)))
		else $error("return did not clear only the high level");
	AST_ORDER: assert property ((grant_ok && !irq_ack_in && !return_from_irq_instr_done_in && !hi_ok)
		|-> (cand_lo[win_src] && (cand_lo & ~({NUM_SRC{1'b1}} << win_src)) == '0)
		##1 (req_reg.src == $past(win_src) && !req_reg.level))
		else $error("arbitration order broken");

endmodule : tlvic_ctrl
`default_nettype wire

// [tlvic_pkg.sv]
// shared constants and types for the two-level vectored interrupt controller
package tlvic_pkg;
	// sources and vectors
	localparam int          NUM_SRC      = 12;
	localparam int          SRC_W        = 4;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] VEC_BASE     = 16'h0003;
	localparam logic [15:0] VEC_STEP     = 16'h0008;
	localparam logic [15:0] VEC_LAST     = 16'h005b;
	// source order positions
	localparam int          SRC_EXT_PIN0  = 0;
	localparam int          SRC_TIMER0    = 1;
	localparam int          SRC_EXT_PIN1  = 2;
	localparam int          SRC_TIMER1    = 3;
	localparam int          SRC_SERIAL    = 4;
	localparam int          SRC_TIMER2    = 5;
	localparam int          SRC_SMBUS     = 6;
	localparam int          SRC_CONV_WIN  = 7;
	localparam int          SRC_CONV_DONE = 8;
	localparam int          SRC_CNT_ARRAY = 9;
	localparam int          SRC_CMP_FALL  = 10;
	localparam int          SRC_CMP_RISE  = 11;
	// flags cleared by hardware on vectoring: both pins, timer0, timer1
	localparam logic [11:0] HW_CLR_MASK  = 12'h00f;
	// cycle figures of the core handshake
	localparam int          CLK_PERIOD_NS  = 5;
	localparam int          DETECT_CYCLES  = 1;
	localparam int          LONG_CALL_INSTR_CYCLES   = 4;
	localparam int          RETURN_FROM_IRQ_INSTR_CYCLES    = 5;
	localparam int          DIV_CYCLES     = 8;
	localparam int          MIN_RESPONSE   = DETECT_CYCLES + LONG_CALL_INSTR_CYCLES;
	localparam int          WORST_RESPONSE = DETECT_CYCLES + RETURN_FROM_IRQ_INSTR_CYCLES + DIV_CYCLES
		+ LONG_CALL_INSTR_CYCLES;
	localparam logic [2:0]  LONG_CALL_INSTR_LAST     = 3'(LONG_CALL_INSTR_CYCLES - 1);
	// register map (byte addresses)
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  ADDR_ENABLE   = 8'h00;
	localparam logic [7:0]  ADDR_PRIO     = 8'h04;
	localparam logic [7:0]  ADDR_EXT_PRIO = 8'h08;
	localparam logic [7:0]  ADDR_PENDING  = 8'h0c;
	localparam logic [7:0]  ADDR_STATUS   = 8'h10;
	localparam int          GLOBAL_EN_BIT = 31;
	localparam int          PRIO_SPLIT    = 6;
	localparam logic [5:0]  PRIO_RESET    = 6'h00;
	localparam logic [11:0] EN_RESET      = 12'h000;
	// status register fields
	localparam int          ST_ISR_LOW   = 0;
	localparam int          ST_ISR_HIGH  = 1;
	localparam int          ST_REQ       = 2;
	localparam int          ST_LEVEL     = 3;
	localparam int          ST_SRC_LSB   = 4;
	localparam int          ST_FSM_LSB   = 8;
	localparam int          ST_VEC_LSB   = 16;
	// bus answers
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {
		ST_RUN  = 2'h0,
		ST_CALL = 2'h1,
		ST_HOLD = 2'h2
	} tlvic_fsm_t;

	typedef struct packed {
		logic              valid;
		logic              level;
		logic [SRC_W-1:0]  src;
		logic [15:0]       vector;
	} tlvic_req_t;
endpackage : tlvic_pkg

// [tlvic_core_model.sv]
// core sequencer model: acks shown vectors, spends the long call, signals returns
`timescale 1ns/1ps
`default_nettype none
module tlvic_core_model
	import tlvic_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       reset_n_in,
	// controller side
	input  wire tlvic_req_t irq_req_in,
	input  wire logic       auto_ack_in,
	output logic            irq_ack_out,
	output logic            return_from_irq_instr_done_out,
	output logic            instr_done_out
);
	tlvic_req_t taken_reg;
	int         ack_cnt;
	int         call_cnt;

	initial
	begin
		return_from_irq_instr_done_out = 1'b0;
		instr_done_out = 1'b0;
	end

	// ack only what is shown, then stay busy for the long call
	always @(posedge ref_clk_in or negedge reset_n_in)
		if (!reset_n_in)
		begin
			irq_ack_out <= 1'b0;
			call_cnt <= 0;
			ack_cnt <= 0;
		end
		else
		begin
			irq_ack_out <= 1'b0;
			if (irq_ack_out)
			begin
				taken_reg <= irq_req_in;
				ack_cnt <= ack_cnt + 1;
			end
			if (call_cnt > 0)
				call_cnt <= call_cnt - 1;
			else if (auto_ack_in && irq_req_in.valid)
			begin
				irq_ack_out <= 1'b1;
				call_cnt <= LONG_CALL_INSTR_CYCLES;
			end
		end

	task automatic do_return_from_irq_instr();
		@(posedge ref_clk_in);
		return_from_irq_instr_done_out <= 1'b1;
		@(posedge ref_clk_in);
		return_from_irq_instr_done_out <= 1'b0;
	endtask : do_return_from_irq_instr

	// the one instruction run after a return; cycles models its length
	task automatic do_instr(input int cycles);
		repeat (cycles) @(posedge ref_clk_in);
		instr_done_out <= 1'b1;
		@(posedge ref_clk_in);
		instr_done_out <= 1'b0;
	endtask : do_instr
endmodule : tlvic_core_model
`default_nettype wire

// [tb.sv]
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb
	import tlvic_pkg::*;
();
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [11:0] ev = 12'h000;
	logic        auto = 1'b0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        arvalid = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [11:0] pend;
	tlvic_req_t  req;
	logic        ack, return_from_irq_instr, instr;
	int          error_cnt = 0;
	int          check_count = 0;

	tlvic_ctrl dut (.ref_clk_in(clk), .reset_n_in(rst_n), .src_event_in(ev),
		.irq_ack_in(ack), .return_from_irq_instr_done_in(return_from_irq_instr), .instr_done_in(instr), .irq_req_out(req),
		.pending_out(pend), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(1'b1), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(1'b1), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp));

	tlvic_core_model core (.ref_clk_in(clk), .reset_n_in(rst_n), .irq_req_in(req),
		.auto_ack_in(auto), .irq_ack_out(ack), .return_from_irq_instr_done_out(return_from_irq_instr),
		.instr_done_out(instr));

	initial
		forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask : step

	// bready and rready stay high, so answers are taken at once
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge clk);
			if (!aw_ok && awready)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		chk(32'(bresp), 32'(er));
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
	endtask : rd

	task automatic pulse(input logic [11:0] m);
		ev <= m;
		@(posedge clk);
		ev <= 12'h000;
	endtask : pulse

	task automatic wait_ack(input int n0);
		int k;
		k = 0;
		while (core.ack_cnt == n0 && k < 40)
		begin
			@(posedge clk);
			k++;
		end
		chk(32'(k < 40), 1);
	endtask : wait_ack

	task automatic chk_status(input logic [1:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(ADDR_STATUS, d, r);
		chk(32'(d[1:0]), 32'(exp));
		chk(32'(r), 32'(RESP_OKAY));
	endtask : chk_status

	task automatic t_reset();
		logic [7:0]  adr [4];
		logic [31:0] d;
		logic [1:0]  r;
		adr = '{ADDR_ENABLE, ADDR_PRIO, ADDR_EXT_PRIO, ADDR_PENDING};
		chk(32'(req.valid), 0);
		chk(32'(req.vector), 32'(RESET_VECTOR));
		for (int i = 0; i < 4; i++)
		begin
			rd(adr[i], d, r);
			chk(d, 0);
		end
		rd(8'h20, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(8'h20, 32'hffff_ffff, 4'hf, RESP_SLVERR);
		$display("test reset done");
	endtask : t_reset

	task automatic t_vectors();
		int n;
		wr(ADDR_ENABLE, 32'h8000_0fff, 4'hf, RESP_OKAY);
		auto <= 1'b1;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			n = core.ack_cnt;
			if (i % 2)
				wr(ADDR_PENDING, 32'h1 << i, 4'hf, RESP_OKAY);
			else
			begin
				pulse(12'h001 << i);
				step(1);
				chk(32'(req.valid), 0);
				step(1);
				chk(32'(req.valid), 1);
			end
			wait_ack(n);
			chk(32'(core.taken_reg.src), i);
			chk(32'(core.taken_reg.vector), 32'(VEC_BASE) + 32'(VEC_STEP) * i);
			chk(32'(pend[i]), 32'(i > 3));
			wr(ADDR_PENDING, 32'h0, 4'hf, RESP_OKAY);
			core.do_return_from_irq_instr();
			core.do_instr(1);
		end
		chk(32'(core.taken_reg.vector), 32'(VEC_LAST));
		auto <= 1'b0;
		$display("test vectors done");
	endtask : t_vectors

	task automatic t_prio();
		logic [31:0] d;
		logic [1:0]  r;
		wr(ADDR_EXT_PRIO, 32'h8, 4'hf, RESP_OKAY);
		pulse(12'h224);
		step(3);
		chk(32'(req.src), 9);
		chk(32'(req.level), 1);
		wr(ADDR_EXT_PRIO, 32'h0, 4'hf, RESP_OKAY);
		step(2);
		chk(32'(req.src), 2);
		chk(32'(req.level), 0);
		wr(ADDR_ENABLE, 32'h0000_0fff, 4'hf, RESP_OKAY);
		step(2);
		chk(32'(req.valid), 0);
		chk(32'(pend), 32'h224);
		wr(ADDR_ENABLE, 32'h8000_0ffb, 4'hf, RESP_OKAY);
		step(2);
		chk(32'(req.src), 5);
		rd(ADDR_STATUS, d, r);
		chk(32'(d[31:16]), 32'(VEC_BASE) + 32'(VEC_STEP) * 5);
		chk(32'(d[7:2]), 32'h15);
		wr(ADDR_PRIO, 32'h20, 4'hf, RESP_OKAY);
		wr(ADDR_PRIO, 32'h3f, 4'h0, RESP_OKAY);
		rd(ADDR_PRIO, d, r);
		chk(d, 32'h20);
		$display("test priority done");
	endtask : t_prio

	// source 5 is high, 9 low, 2 masked; pending holds 2, 5 and 9
	task automatic t_nest();
		int n;
		n = core.ack_cnt;
		auto <= 1'b1;
		wait_ack(n);
		chk(32'(core.taken_reg.src), 5);
		chk_status(2'b10);
		step(8);
		chk(32'(req.valid), 0);
		auto <= 1'b0;
		wr(ADDR_PENDING, 32'h200, 4'hf, RESP_OKAY);
		core.do_return_from_irq_instr();
		chk_status(2'b00);
		chk(32'(req.valid), 0);
		core.do_instr(DIV_CYCLES);
		step(1);
		chk(32'(req.valid), 0);
		step(1);
		chk(32'(req.valid), 1);
		chk(32'(req.src), 9);
		n = core.ack_cnt;
		auto <= 1'b1;
		wait_ack(n);
		chk_status(2'b01);
		step(8);
		chk(32'(req.valid), 0);
		n = core.ack_cnt;
		pulse(12'h020);
		wait_ack(n);
		chk(32'(core.taken_reg.src), 5);
		chk_status(2'b11);
		auto <= 1'b0;
		wr(ADDR_PENDING, 32'h0, 4'hf, RESP_OKAY);
		core.do_return_from_irq_instr();
		chk_status(2'b01);
		core.do_instr(1);
		core.do_return_from_irq_instr();
		chk_status(2'b00);
		$display("test nesting done");
	endtask : t_nest

	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_vectors();
		t_prio();
		t_nest();
		stop_test();
	end

	initial
	begin
		#(CLK_PERIOD_NS * 20000);
		error_cnt++;
		$display("watchdog expired");
		stop_test();
	end
endmodule : tb
`default_nettype wire
